/* File: dv/rpfm_rtc_model.sv */
module rpfm_rtc_model
   import rpfm_pkg::*;
(
   input wire logic clk,
   input wire logic ext,
   input wire logic irq_n,
   input wire logic pstrb_n,
   input wire logic pgood,
   input wire logic rd_o,
   input wire logic rd_oe_n,
   input wire logic ale_o,
   input wire logic ale_oe_n,
   output logic tb_pin,
   output logic rd_pin,
   output logic ale_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF_PERIOD = CORE_FREQ_HZ / (2 * OSC_FREQ_HZ);
   int cnt = 0;
   logic osc = 1'b0;
   // half period of the 32 khz crystal at 40 mhz
   always @(posedge clk) begin
      cnt <= (cnt == HALF_PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == HALF_PERIOD - 1) osc <= ~osc;
   end
   assign tb_pin = ext ? irq_n : osc;
   assign rd_pin = rd_oe_n ? pstrb_n : rd_o;
   assign ale_pin = ale_oe_n ? pgood : ale_o;
endmodule // rpfm_rtc_model

/* File: dv/tb_rtc_pin_function_mux.sv */
module tb_rtc_pin_function_mux
   import rpfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, mode = MODE_INTERNAL, vld = 1'b0, wr = 1'b0, ap = 1'b0;
   logic irq_n = 1'b1, pstrb_n = 1'b1, pgood = 1'b1;
   logic tb_pin, rd_pin, ale_pin, rd_o, rd_oe_n, wr_o, ale_o, ale_oe_n, tick, irq, pstrb, conn;
   int fail_count = 0;
   int n_compared = 0;
   always #12.5 clk = ~clk;
   rpfm_top u_rpfm_top (.CORE_CLK(clk), .SYS_RST(rst), .MODE_EXT(mode), .CPU_RTC_VALID(vld),
      .CPU_RTC_WRITE(wr), .CPU_RTC_ADDR_PHASE(ap), .TIMEBASE_OR_IRQ_PIN(tb_pin),
      .RD_STROBE_OR_POWER_STROBE_I(rd_pin), .RD_STROBE_OR_POWER_STROBE_O(rd_o),
      .RD_STROBE_OR_POWER_STROBE_OE_N(rd_oe_n), .WR_STROBE_OR_OSC_OUT(wr_o),
      .ADDR_LATCH_OR_POWER_GOOD_I(ale_pin), .ADDR_LATCH_OR_POWER_GOOD_O(ale_o),
      .ADDR_LATCH_OR_POWER_GOOD_OE_N(ale_oe_n), .RTC_TIMEBASE_TICK(tick), .IRQ_REQ(irq),
      .RTC_POWER_STROBE(pstrb), .RTC_CONNECTED(conn));
   rpfm_rtc_model u_rpfm_rtc_model (.clk(clk), .ext(mode), .irq_n(irq_n), .pstrb_n(pstrb_n),
      .pgood(pgood), .rd_o(rd_o), .rd_oe_n(rd_oe_n), .ale_o(ale_o), .ale_oe_n(ale_oe_n),
      .tb_pin(tb_pin), .rd_pin(rd_pin), .ale_pin(ale_pin));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // strobe requests must be ignored while the crystal runs
   task automatic t_internal;
      int n;
      n = 0;
      vld = 1'b1;
      ap = 1'b1;
      while (tick !== 1'b1 && n < 1400) begin
         step(1);
         n++;
      end
      chk("tick", 1'b1, tick);
      chk("ale", 1'b0, ale_o);
      chk("rd oe", 1'b1, rd_oe_n);
      vld = 1'b0;
      step(1);
      chk("tick end", 1'b0, tick);
      pstrb_n = 1'b0;
      pgood = 1'b0;
      // three sync flops, the agree stage, then the output flop
      step(5);
      chk("pstrb", 1'b1, pstrb);
      chk("conn low", 1'b0, conn);
      pstrb_n = 1'b1;
      pgood = 1'b1;
      step(5);
      chk("conn", 1'b1, conn);
      chk("pstrb off", 1'b0, pstrb);
   endtask
   task automatic t_external;
      mode = MODE_EXTERNAL;
      step(3);
      chk("rd oe", 1'b0, rd_oe_n);
      chk("ale oe", 1'b0, ale_oe_n);
      vld = 1'b1;
      wr = 1'b1;
      step(1);
      chk("ale", 1'b1, ale_pin);
      ap = 1'b0;
      step(1);
      chk("ale drop", 1'b0, ale_o);
      chk("wr", 1'b1, wr_o);
      wr = 1'b0;
      step(1);
      chk("rd", 1'b1, rd_pin);
      chk("wr drop", 1'b0, wr_o);
      vld = 1'b0;
      irq_n = 1'b0;
      step(1);
      chk("rd drop", 1'b0, rd_o);
      step(4);
      chk("irq", 1'b1, irq);
      irq_n = 1'b1;
      step(5);
      chk("irq off", 1'b0, irq);
   endtask
   initial begin
      step(3);
      rst = 1'b0;
      step(1);
      t_internal();
      t_external();
      end_sim();
   end
   initial begin
      #(25 * 5000);
      fail_count++;
      end_sim();
   end
endmodule // tb_rtc_pin_function_mux

/* File: src/rpfm_pkg.sv */
package rpfm_pkg;
   // ----------------------------------------
   // pin function selection
   // ----------------------------------------
   localparam logic MODE_INTERNAL = 1'b0;
   localparam logic MODE_EXTERNAL = 1'b1;
   localparam int OSC_FREQ_HZ = 32768;
   localparam int CORE_FREQ_HZ = 40000000;
   localparam logic [1:0] SYNC_AGREE = 2'b11;
   localparam logic [1:0] SYNC_LOW = 2'b00;

   typedef enum logic [1:0] {
      RPFM_IDLE,
      RPFM_ADDR,
      RPFM_DATA
   } rpfm_phase_e;

   // cpu request towards the clock
   typedef struct packed {
      logic valid;
      logic write;
      logic addr_phase;
   } rpfm_req_s;

   // three-stage synchroniser for one pin
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } rpfm_sync_s;

   // start value of a synchroniser whose pin idles high
   localparam rpfm_sync_s SYNC_IDLE_HIGH = 4'hf;

   typedef struct packed {
      rpfm_sync_s osc;
      rpfm_sync_s pstrb;
      rpfm_sync_s pgood;
      logic osc_tick;
      logic irq_req;
      logic pstrb_lvl;
      logic rtc_conn;
      logic rd_o;
      logic rd_oe_n;
      logic wr_o;
      logic ale_o;
      logic ale_oe_n;
      logic mode;
   } rpfm_state_s;
endpackage

/* File: src/rpfm_top.sv */
// Function
// - in internal mode the first pin is the 32.768 KHz time base of the built-in clock.
// - in external mode the first pin is an active-low interrupt request to the core.
// - in internal mode the second pin is the power strobe input that presets the clock.
// - in external mode the second pin is driven as the read strobe during clock reads.
// - in external mode the third pin is driven as the write strobe during clock writes.
// - in internal mode the built-in clock is cut off from the cpu while power good is low.
// - in external mode the fourth pin is driven as the address latch strobe.
module rpfm_top
   import rpfm_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic MODE_EXT,
   input wire logic CPU_RTC_VALID,
   input wire logic CPU_RTC_WRITE,
   input wire logic CPU_RTC_ADDR_PHASE,
   input wire logic TIMEBASE_OR_IRQ_PIN,
   input wire logic RD_STROBE_OR_POWER_STROBE_I,
   output logic RD_STROBE_OR_POWER_STROBE_O,
   output logic RD_STROBE_OR_POWER_STROBE_OE_N,
   output logic WR_STROBE_OR_OSC_OUT,
   input wire logic ADDR_LATCH_OR_POWER_GOOD_I,
   output logic ADDR_LATCH_OR_POWER_GOOD_O,
   output logic ADDR_LATCH_OR_POWER_GOOD_OE_N,
   output logic RTC_TIMEBASE_TICK,
   output logic IRQ_REQ,
   output logic RTC_POWER_STROBE,
   output logic RTC_CONNECTED
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   rpfm_state_s st_r;
   rpfm_state_s st_nxt;
   rpfm_req_s req;
   logic ext;

   assign req = '{valid: CPU_RTC_VALID, write: CPU_RTC_WRITE, addr_phase: CPU_RTC_ADDR_PHASE};

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   function automatic rpfm_sync_s sync_step(rpfm_sync_s s, logic pin);
      rpfm_sync_s n;
      n = s;
      n.s1 = pin;
      n.s2 = s.s1;
      n.s3 = s.s2;
      // change counts once stages two and three agree
      if ({s.s2, s.s3} == SYNC_AGREE) begin
         n.q = 1'b1;
      end else if ({s.s2, s.s3} == SYNC_LOW) begin
         n.q = 1'b0;
      end
      return n;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      // mode taken from a stable strap-like input; all pins follow it together
      st_nxt.mode = MODE_EXT;
      ext = st_r.mode;
      st_nxt.osc = sync_step(st_r.osc, TIMEBASE_OR_IRQ_PIN);
      st_nxt.pstrb = sync_step(st_r.pstrb, RD_STROBE_OR_POWER_STROBE_I);
      st_nxt.pgood = sync_step(st_r.pgood, ADDR_LATCH_OR_POWER_GOOD_I);
      // rising edge of the crystal clock; 32 kHz is far below core rate
      st_nxt.osc_tick = (ext == MODE_INTERNAL) && st_nxt.osc.q && !st_r.osc.q;
      st_nxt.irq_req = (ext == MODE_EXTERNAL) && !st_r.osc.q;
      st_nxt.pstrb_lvl = (ext == MODE_INTERNAL) && !st_r.pstrb.q;
      // relies on outside logic keeping power good high over each access
      st_nxt.rtc_conn = (ext == MODE_INTERNAL) && st_r.pgood.q;
      st_nxt.rd_o = (ext == MODE_EXTERNAL) && req.valid && !req.write
                    && !req.addr_phase;
      st_nxt.wr_o = (ext == MODE_EXTERNAL) && req.valid && req.write
                    && !req.addr_phase;
      st_nxt.ale_o = (ext == MODE_EXTERNAL) && req.valid && req.addr_phase;
      // pins turn to outputs only in external mode
      st_nxt.rd_oe_n = (ext != MODE_EXTERNAL);
      st_nxt.ale_oe_n = (ext != MODE_EXTERNAL);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_r <= '0;
         // idle-high start keeps reset from faking an edge, a strobe or an irq
         st_r.osc <= SYNC_IDLE_HIGH;
         st_r.pstrb <= SYNC_IDLE_HIGH;
         // power good starts low so the clock stays isolated until it is seen
         st_r.rd_oe_n <= 1'b1;
         st_r.ale_oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign RTC_TIMEBASE_TICK = st_r.osc_tick;
   assign IRQ_REQ = st_r.irq_req;
   assign RTC_POWER_STROBE = st_r.pstrb_lvl;
   assign RTC_CONNECTED = st_r.rtc_conn;
   assign RD_STROBE_OR_POWER_STROBE_O = st_r.rd_o;
   assign RD_STROBE_OR_POWER_STROBE_OE_N = st_r.rd_oe_n;
   assign WR_STROBE_OR_OSC_OUT = st_r.wr_o;
   assign ADDR_LATCH_OR_POWER_GOOD_O = st_r.ale_o;
   assign ADDR_LATCH_OR_POWER_GOOD_OE_N = st_r.ale_oe_n;

   // ----------------------------------------
   // checks: cpu strobes
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   a_rd_strobe: assert property (
      st_r.mode && req.valid && !req.write && !req.addr_phase |=> RD_STROBE_OR_POWER_STROBE_O)
      else $error("read strobe missing");

   a_wr_strobe: assert property (
      st_r.mode && req.valid && req.write && !req.addr_phase |=> WR_STROBE_OR_OSC_OUT)
      else $error("write strobe missing");

   a_ale_strobe: assert property (
      st_r.mode && req.valid && req.addr_phase |=> ADDR_LATCH_OR_POWER_GOOD_O)
      else $error("latch strobe missing");

   a_rd_drop: assert property (
      st_r.mode && !req.valid |=> !RD_STROBE_OR_POWER_STROBE_O)
      else $error("read strobe stuck");

   a_wr_drop: assert property (
      st_r.mode && !req.valid |=> !WR_STROBE_OR_OSC_OUT)
      else $error("write strobe stuck");

   a_ale_drop: assert property (
      st_r.mode && !req.addr_phase |=> !ADDR_LATCH_OR_POWER_GOOD_O)
      else $error("latch strobe stuck");

   a_one_strobe: assert property (
      $onehot0({RD_STROBE_OR_POWER_STROBE_O, WR_STROBE_OR_OSC_OUT,
      ADDR_LATCH_OR_POWER_GOOD_O}))
      else $error("strobes overlap");

   a_rd_refused: assert property (
      !st_r.mode |=> !RD_STROBE_OR_POWER_STROBE_O)
      else $error("read strobe in internal mode");

   a_ale_refused: assert property (
      !st_r.mode |=> !ADDR_LATCH_OR_POWER_GOOD_O)
      else $error("latch strobe in internal mode");

   a_int_quiet: assert property (
      !st_r.mode |=> !WR_STROBE_OR_OSC_OUT && !IRQ_REQ)
      else $error("strobe in internal mode");

   // ----------------------------------------
   // checks: shared inputs
   // ----------------------------------------
   a_pg_isolate: assert property (
      !st_r.mode && !st_r.pgood.q |=> !RTC_CONNECTED)
      else $error("clock not isolated");

   a_pg_connect: assert property (
      !st_r.mode && st_r.pgood.q |=> RTC_CONNECTED)
      else $error("clock not joined");

   a_ext_isolate: assert property (
      st_r.mode |=> !RTC_CONNECTED && !RTC_POWER_STROBE)
      else $error("internal clock active in external mode");

   a_irq_level: assert property (
      st_r.mode && !st_r.osc.q |=> IRQ_REQ)
      else $error("irq lost");

   a_irq_clear: assert property (
      st_r.osc.q |=> !IRQ_REQ)
      else $error("irq stuck");

   a_tick_int: assert property (
      RTC_TIMEBASE_TICK |-> !$past(st_r.mode))
      else $error("tick in external mode");

   a_tick_pulse: assert property (
      RTC_TIMEBASE_TICK |=> !RTC_TIMEBASE_TICK)
      else $error("tick longer than one cycle");

   a_tick_edge: assert property (
      RTC_TIMEBASE_TICK |-> st_r.osc.q && !$past(st_r.osc.q))
      else $error("tick without rising time base");

   a_pstrb_int: assert property (
      !st_r.mode && !st_r.pstrb.q |=> RTC_POWER_STROBE)
      else $error("power strobe lost");

   a_pstrb_off: assert property (
      st_r.pstrb.q |=> !RTC_POWER_STROBE)
      else $error("power strobe stuck");

   a_sync_agree: assert property (
      st_r.osc.s2 && st_r.osc.s3 |=> st_r.osc.q)
      else $error("synchroniser missed a high level");

   a_sync_low: assert property (
      !st_r.osc.s2 && !st_r.osc.s3 |=> !st_r.osc.q)
      else $error("synchroniser missed a low level");

   // ----------------------------------------
   // checks: pin directions
   // ----------------------------------------
   a_dir_follow: assert property (
      $stable(st_r.mode)[*2] |-> RD_STROBE_OR_POWER_STROBE_OE_N == !st_r.mode)
      else $error("dir mismatch");

   a_ale_dir: assert property (
      $stable(st_r.mode)[*2] |-> ADDR_LATCH_OR_POWER_GOOD_OE_N == !st_r.mode)
      else $error("latch dir mismatch");

   a_oe_pair: assert property (
      ADDR_LATCH_OR_POWER_GOOD_OE_N == RD_STROBE_OR_POWER_STROBE_OE_N)
      else $error("pin directions split");

   a_rd_driven: assert property (
      RD_STROBE_OR_POWER_STROBE_O |-> !RD_STROBE_OR_POWER_STROBE_OE_N)
      else $error("read strobe on undriven pin");

   a_wr_driven: assert property (
      WR_STROBE_OR_OSC_OUT |-> !RD_STROBE_OR_POWER_STROBE_OE_N)
      else $error("write strobe outside external mode");

   a_ale_driven: assert property (
      ADDR_LATCH_OR_POWER_GOOD_O |-> !ADDR_LATCH_OR_POWER_GOOD_OE_N)
      else $error("latch strobe on undriven pin");

   a_mode_reg: assert property (
      1'b1 |=> st_r.mode == $past(MODE_EXT))
      else $error("mode register lags");

   // ----------------------------------------
   // covers
   // ----------------------------------------
   c_ext_read: cover property (st_r.mode ##1 RD_STROBE_OR_POWER_STROBE_O);
   c_ext_write: cover property (st_r.mode ##1 WR_STROBE_OR_OSC_OUT);
   c_ext_latch: cover property (st_r.mode ##1 ADDR_LATCH_OR_POWER_GOOD_O);
   c_ext_irq: cover property (IRQ_REQ);
   c_int_tick: cover property (RTC_TIMEBASE_TICK);
endmodule // rpfm_top
